// [design/dmaed_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
module dmaed_ctrl (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   dmaed_link_if.ctl link,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [dmaed_pkg::AW-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic o_irq
);
   import dmaed_pkg::*;

   logic [31:0] pol_ff;
   logic [31:0] ena_ff;
   logic [31:0] grp_ff;
   logic [31:0] soft_ff;
   logic [IRQ_N-1:0] stat_ff;
   logic [IRQ_N-1:0] mask_ff;
   logic [MEM_SEL_BIT:0] maddr_ff;
   logic mem_we_ff;
   logic [31:0] mem_wdata_ff;
   logic acc;
   logic wr;
   logic rd_stat;
   logic hit;
   logic [31:0] rdata;
   logic [IRQ_N-1:0] stat_nxt;

   // one wait state: pready rises in the second access cycle
   assign acc = i_psel & i_penable & o_pready;
   assign wr = acc & i_pwrite;
   assign rd_stat = acc & ~i_pwrite & (i_paddr == REG_IRQ_STAT);

   always_comb begin
      hit = 1'b1;
      rdata = '0;
      case (i_paddr)
         REG_POL: rdata = pol_ff;
         REG_ENA: rdata = ena_ff;
         REG_GRP: rdata = grp_ff;
         REG_SOFT: rdata = soft_ff;
         REG_FLAG: rdata = link.flags;
         REG_STATE: rdata = link.state;
         REG_IRQ_STAT: rdata = 32'(stat_ff);
         REG_IRQ_MASK: rdata = 32'(mask_ff);
         REG_MEM_ADDR: rdata = 32'(maddr_ff);
         REG_MEM_DATA: rdata = mem_wdata_ff;
         default: hit = 1'b0;
      endcase
   end

   // apb handshake and read data
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pready <= 1'b0;
         o_prdata <= RST_ZERO;
         o_pslverr <= 1'b0;
      end else if (i_clk_en) begin
         o_pready <= i_psel & i_penable & ~o_pready;
         o_prdata <= (i_psel & i_penable & ~o_pready & ~i_pwrite) ? rdata : RST_ZERO;
         o_pslverr <= i_psel & i_penable & ~o_pready & ~hit;
      end
   end

   // configuration registers; software owns entry setup order
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pol_ff <= '0;
         ena_ff <= '0;
         grp_ff <= '0;
         soft_ff <= '0;
         mask_ff <= '0;
         maddr_ff <= '0;
      end else if (i_clk_en && wr) begin
         case (i_paddr)
            REG_POL: pol_ff <= i_pwdata;
            REG_ENA: ena_ff <= i_pwdata;
            REG_GRP: grp_ff <= i_pwdata;
            REG_SOFT: soft_ff <= i_pwdata;
            REG_IRQ_MASK: mask_ff <= i_pwdata[IRQ_N-1:0];
            REG_MEM_ADDR: maddr_ff <= i_pwdata[MEM_SEL_BIT:0];
            default: ;
         endcase
      end
   end

   // entry words go to the memory picked by the select bit
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mem_we_ff <= 1'b0;
         mem_wdata_ff <= RST_ZERO;
      end else if (i_clk_en) begin
         mem_we_ff <= wr & (i_paddr == REG_MEM_DATA);
         if (wr && i_paddr == REG_MEM_DATA) begin
            mem_wdata_ff <= i_pwdata;
         end
      end
   end

   // read clears only the bits just reported, so a pulse that lands
   // after the read data was taken stays set; a new pulse beats the clear
   always_comb begin
      stat_nxt = (stat_ff & ~(rd_stat ? o_prdata[IRQ_N-1:0] : '0)) | link.irq_pulse;
   end

   // sticky status and level interrupt
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stat_ff <= '0;
         o_irq <= 1'b0;
      end else if (i_clk_en) begin
         stat_ff <= stat_nxt;
         o_irq <= |(stat_nxt & mask_ff);
      end
   end

   assign link.polarity = pol_ff;
   assign link.enable = ena_ff;
   assign link.group_hi = grp_ff;
   assign link.soft_trig = soft_ff;
   assign link.mem_we = mem_we_ff;
   assign link.mem_sel_hi = maddr_ff[MEM_SEL_BIT];
   assign link.mem_addr = maddr_ff[MEM_AW-1:0];
   assign link.mem_wdata = mem_wdata_ff;

endmodule : dmaed_ctrl
`default_nettype wire

// [design/dmaed_device.sv]
`timescale 1ns/10ps
`default_nettype none
module dmaed_device #(
   parameter int XFER_ENTRIES = dmaed_pkg::XFER_ENTRIES
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   dmaed_link_if.dev link,
   input wire logic [3:0] i_counter_request,
   input wire logic [2:0] i_audio_tx_req,
   input wire logic [2:0] i_audio_rx_req,
   input wire logic i_host_port_interrupt,
   input wire logic [1:0] i_spi_rx_req,
   input wire logic [1:0] i_i2c_tx_req,
   input wire logic [1:0] i_i2c_rx_req,
   input wire logic [2:0] i_external_mute_input,
   input wire logic [2:0] i_audio_tx_err,
   input wire logic [2:0] i_audio_rx_err,
   input wire logic i_counter_overflow_error,
   input wire logic [dmaed_pkg::NUM_GRP-1:0] i_eng_ack,
   output logic [dmaed_pkg::NUM_GRP-1:0] o_eng_req,
   output logic [dmaed_pkg::NUM_GRP-1:0][dmaed_pkg::EVT_W-1:0] o_eng_evt_num,
   output logic [dmaed_pkg::NUM_GRP-1:0][31:0] o_eng_evt_entry,
   output logic [dmaed_pkg::NUM_GRP-1:0][dmaed_pkg::XFER_WORDS-1:0][31:0] o_eng_xfer
);
   import dmaed_pkg::*;

   // table layout only holds eight four-word transfer entries
   if (XFER_ENTRIES != 8) begin : g_chk
      $error("dmaed_device: XFER_ENTRIES must be 8");
   end

   logic [NUM_EVT-1:0] raw_pins;
   logic [NUM_EVT-1:0] sync1_ff;
   logic [NUM_EVT-1:0] sync2_ff;
   logic [NUM_EVT-1:0] nxt_state;
   logic [NUM_EVT-1:0] state_ff;
   logic [NUM_EVT-1:0] prev_ff;
   logic [NUM_EVT-1:0] edge_hit;
   logic [NUM_EVT-1:0] flag_ff;
   logic [NUM_GRP-1:0][NUM_EVT-1:0] clr_by_grp;
   logic [NUM_GRP-1:0][IRQ_N-1:0] irq_by_grp;
   logic [IRQ_N-1:0] irq_ff;
   logic [31:0] mem_ff [NUM_GRP][MEM_DEPTH];

   // lowest event number wins inside a group
   function automatic logic [EVT_W-1:0] first_set(input logic [NUM_EVT-1:0] v);
      logic [EVT_W-1:0] r;
      r = '0;
      for (int i = NUM_EVT - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = EVT_W'(i);
         end
      end
      return r;
   endfunction : first_set

   // pin events gathered into their event slots
   always_comb begin
      raw_pins = '0;
      raw_pins[EV_RTC0] = i_counter_request[0];
      raw_pins[EV_RTC1] = i_counter_request[1];
      raw_pins[EV_RTC2] = i_counter_request[2];
      raw_pins[EV_RTC3] = i_counter_request[3];
      for (int a = 0; a < 3; a++) begin
         raw_pins[EV_AUD_BASE + 2 * a] = i_audio_tx_req[a];
         raw_pins[EV_AUD_BASE + 2 * a + 1] = i_audio_rx_req[a];
         // any of three sources, software must look for the cause
         raw_pins[EV_AUDERR_BASE + a] = i_external_mute_input[a] | i_audio_tx_err[a]
            | i_audio_rx_err[a];
      end
      raw_pins[EV_HOST] = i_host_port_interrupt;
      raw_pins[EV_SPI0] = i_spi_rx_req[0];
      raw_pins[EV_SPI1] = i_spi_rx_req[1];
      for (int c = 0; c < 2; c++) begin
         raw_pins[EV_I2C_BASE + 2 * c] = i_i2c_tx_req[c];
         raw_pins[EV_I2C_BASE + 2 * c + 1] = i_i2c_rx_req[c];
      end
      raw_pins[EV_OVF] = i_counter_overflow_error;
      raw_pins[EV_RSVD] = 1'b0;
   end

   // two-stage synchroniser on the asynchronous pins
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end else if (i_clk_en) begin
         sync1_ff <= raw_pins;
         sync2_ff <= sync1_ff;
      end
   end

   // soft trigger bits join the event state; host logic shares our clock
   always_comb begin
      nxt_state = sync2_ff;
      for (int s = 0; s < SOFT_N; s++) begin
         nxt_state[SOFT_EVT[s]] = link.soft_trig[SOFT_BIT[s]];
      end
      nxt_state[EV_RSVD] = 1'b0;
   end

   // event state register and its previous value for edge detect
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_ff <= '0;
         prev_ff <= '0;
      end else if (i_clk_en) begin
         state_ff <= nxt_state;
         prev_ff <= state_ff;
      end
   end

   // polarity 1 takes rising edges, 0 falling edges
   assign edge_hit = (link.polarity & state_ff & ~prev_ff)
      | (~link.polarity & ~state_ff & prev_ff);

   // flags: new edge wins over a clear in the same cycle
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         flag_ff <= '0;
      end else if (i_clk_en) begin
         flag_ff <= (flag_ff & ~(clr_by_grp[GRP_HI] | clr_by_grp[GRP_LO]))
            | (edge_hit & link.enable);
      end
   end

   // parameter memories, one per group, written by the controller
   always_ff @(posedge i_sys_clk) begin
      if (i_clk_en && link.mem_we) begin
         if (link.mem_sel_hi) begin
            mem_ff[GRP_HI][link.mem_addr] <= link.mem_wdata;
         end else begin
            mem_ff[GRP_LO][link.mem_addr] <= link.mem_wdata;
         end
      end
   end

   // one dispatcher per group, each running independently
   for (genvar g = 0; g < NUM_GRP; g++) begin : g_disp
      dmaed_disp_type st_ff;
      logic [NUM_EVT-1:0] pend;
      logic [EVT_W-1:0] pick;
      logic [EVT_W-1:0] evt_ff;
      logic [EE_PTR_W-1:0] ptr_ff;
      logic [1:0] wcnt_ff;
      logic [31:0] entry;
      logic [MEM_AW-1:0] xaddr;

      // only events sorted into this group are visible here
      assign pend = flag_ff & ((g == GRP_HI) ? link.group_hi : ~link.group_hi);
      assign pick = first_set(pend);
      // fetch only from this group's own memory
      assign entry = mem_ff[g][MEM_AW'(evt_ff)];
      assign xaddr = XFER_BASE + MEM_AW'({ptr_ff, wcnt_ff});

      always_comb begin
         clr_by_grp[g] = '0;
         if (st_ff == DISP_IDLE && i_clk_en && (|pend)) begin
            clr_by_grp[g][pick] = 1'b1;
         end
      end

      always_comb begin
         irq_by_grp[g] = '0;
         if (st_ff == DISP_EVT && entry[EE_KIND_BIT]) begin
            irq_by_grp[g][entry[EE_IRQ_LSB +: EE_IRQ_W]] = 1'b1;
         end
      end

      // at most one event in flight per group
      always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
         if (!i_rst_n) begin
            st_ff <= DISP_IDLE;
            evt_ff <= '0;
            ptr_ff <= '0;
            wcnt_ff <= '0;
            o_eng_req[g] <= 1'b0;
            o_eng_evt_num[g] <= '0;
            o_eng_evt_entry[g] <= RST_ZERO;
            o_eng_xfer[g] <= '0;
         end else if (i_clk_en) begin
            case (st_ff)
               DISP_IDLE: begin
                  if (|pend) begin
                     evt_ff <= pick;
                     st_ff <= DISP_EVT;
                  end
               end
               DISP_EVT: begin
                  o_eng_evt_num[g] <= evt_ff;
                  o_eng_evt_entry[g] <= entry;
                  ptr_ff <= entry[EE_PTR_LSB +: EE_PTR_W];
                  wcnt_ff <= '0;
                  // interrupt-type entries finish here, no engine work
                  st_ff <= entry[EE_KIND_BIT] ? DISP_IDLE : DISP_XFER;
               end
               DISP_XFER: begin
                  o_eng_xfer[g][wcnt_ff] <= mem_ff[g][xaddr];
                  wcnt_ff <= wcnt_ff + 2'd1;
                  if (wcnt_ff == 2'(XFER_WORDS - 1)) begin
                     o_eng_req[g] <= 1'b1;
                     st_ff <= DISP_REQ;
                  end
               end
               DISP_REQ: begin
                  if (i_eng_ack[g]) begin
                     o_eng_req[g] <= 1'b0;
                     st_ff <= DISP_IDLE;
                  end
               end
               default: begin
                  st_ff <= DISP_IDLE;
               end
            endcase
         end
      end
   end

   // status back to the controller, all registered
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_ff <= '0;
      end else if (i_clk_en) begin
         irq_ff <= irq_by_grp[GRP_HI] | irq_by_grp[GRP_LO];
      end
   end

   assign link.flags = flag_ff;
   assign link.state = state_ff;
   assign link.irq_pulse = irq_ff;

endmodule : dmaed_device
`default_nettype wire

// [design/dmaed_link_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface dmaed_link_if;
   import dmaed_pkg::*;
   logic [NUM_EVT-1:0] polarity;
   logic [NUM_EVT-1:0] enable;
   logic [NUM_EVT-1:0] group_hi;
   logic [31:0] soft_trig;
   logic mem_we;
   logic mem_sel_hi;
   logic [MEM_AW-1:0] mem_addr;
   logic [31:0] mem_wdata;
   logic [NUM_EVT-1:0] flags;
   logic [NUM_EVT-1:0] state;
   logic [IRQ_N-1:0] irq_pulse;
   modport dev (input polarity, enable, group_hi, soft_trig, mem_we, mem_sel_hi, mem_addr,
      mem_wdata, output flags, state, irq_pulse);
   modport ctl (output polarity, enable, group_hi, soft_trig, mem_we, mem_sel_hi, mem_addr,
      mem_wdata, input flags, state, irq_pulse);
endinterface : dmaed_link_if
`default_nettype wire

// [design/dmaed_pkg.sv]
// Behaviour
// - software sets up both entries before enabling
// - event entry gives type, details, transfer pointer
// - transfer entry gives source, destination, counts, indexes
// - high group entries live in high memory
// - low group entries live in low memory
// - flag register latches each event independently
// - encoder orders simultaneous pending events by priority
// - one event per group, both groups concurrently
// - enabled event launches request without cpu
// - soft trigger bit edge acts as event
// - soft trigger bits map to fixed events
// - peripheral requests map to fixed events
// - error events ored, overflow 29, 25 reserved
// - edge polarity selectable per event
// - each engine serves only its own group
// - entry may raise named cpu interrupt instead
package dmaed_pkg;
   localparam int NUM_EVT = 32;
   localparam int EVT_W = 5;
   localparam int NUM_GRP = 2;
   localparam int GRP_HI = 0;
   localparam int GRP_LO = 1;
   localparam int MEM_AW = 6;
   localparam int MEM_DEPTH = 64;
   localparam int IRQ_N = 16;
   // transfer table: entries of four words after the event table
   localparam int XFER_ENTRIES = 8;
   localparam int XFER_WORDS = 4;
   localparam logic [MEM_AW-1:0] XFER_BASE = 6'h20;
   // event entry fields
   localparam int EE_KIND_BIT = 0;
   localparam int EE_PTR_LSB = 1;
   localparam int EE_PTR_W = 3;
   localparam int EE_IRQ_LSB = 4;
   localparam int EE_IRQ_W = 4;
   // event numbers
   localparam int EV_RTC0 = 2;
   localparam int EV_RTC1 = 3;
   localparam int EV_AUD_BASE = 4;
   localparam int EV_HOST = 12;
   localparam int EV_SPI0 = 13;
   localparam int EV_SPI1 = 14;
   localparam int EV_RTC2 = 15;
   localparam int EV_RTC3 = 16;
   localparam int EV_I2C_BASE = 19;
   localparam int EV_RSVD = 25;
   localparam int EV_AUDERR_BASE = 26;
   localparam int EV_OVF = 29;
   localparam int SOFT_N = 10;
   localparam int SOFT_BIT [SOFT_N] = '{0, 16, 1, 17, 2, 18, 3, 19, 20, 21};
   localparam int SOFT_EVT [SOFT_N] = '{0, 1, 10, 11, 17, 18, 23, 24, 30, 31};
   // apb register offsets
   localparam int AW = 8;
   localparam logic [AW-1:0] REG_POL = 8'h00;
   localparam logic [AW-1:0] REG_ENA = 8'h04;
   localparam logic [AW-1:0] REG_GRP = 8'h08;
   localparam logic [AW-1:0] REG_SOFT = 8'h0c;
   localparam logic [AW-1:0] REG_FLAG = 8'h10;
   localparam logic [AW-1:0] REG_STATE = 8'h14;
   localparam logic [AW-1:0] REG_IRQ_STAT = 8'h18;
   localparam logic [AW-1:0] REG_IRQ_MASK = 8'h1c;
   localparam logic [AW-1:0] REG_MEM_ADDR = 8'h20;
   localparam logic [AW-1:0] REG_MEM_DATA = 8'h24;
   localparam int MEM_SEL_BIT = 6;
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   typedef enum logic [1:0] {DISP_IDLE, DISP_EVT, DISP_XFER, DISP_REQ} dmaed_disp_type;
endpackage : dmaed_pkg

// [tb/dmaed_link_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module dmaed_link_monitor (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic [dmaed_pkg::NUM_EVT-1:0] polarity,
   input wire logic [dmaed_pkg::NUM_EVT-1:0] enable,
   input wire logic [31:0] soft_trig,
   input wire logic [dmaed_pkg::NUM_EVT-1:0] flags,
   input wire logic [dmaed_pkg::NUM_EVT-1:0] state,
   input wire logic [dmaed_pkg::IRQ_N-1:0] irq_pulse
);
   import dmaed_pkg::*;
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_n);
   logic flag_any;
   // any pending flag, kept as a net so $past sees one signal
   assign flag_any = |flags;
   sequence s_hold_hi(sig);
      sig [*3];
   endsequence
   sequence s_hold_lo(sig);
      !sig [*3];
   endsequence
   // soft trigger levels must show on the mapped event state; other event bits are not checked
   for (genvar k = 0; k < SOFT_N; k++) begin : g_soft
      AST_SOFT_HI: assert property (s_hold_hi(soft_trig[SOFT_BIT[k]])
         |-> state[SOFT_EVT[k]])
         else $error("soft trigger high not seen in event state");
      AST_SOFT_LO: assert property (s_hold_lo(soft_trig[SOFT_BIT[k]])
         |-> !state[SOFT_EVT[k]])
         else $error("soft trigger low not seen in event state");
   end
   // flags follow enabled edges of the chosen polarity
   for (genvar k = 0; k < NUM_EVT; k++) begin : g_flag
      AST_FLAG_ENA: assert property ($rose(flags[k]) |-> $past(enable[k]))
         else $error("flag set on a disabled event");
      // the flag is set one cycle after the edge, so judge the edge cycle
      AST_FLAG_POL: assert property ($rose(flags[k])
         |-> $past(state[k]) == $past(polarity[k]))
         else $error("flag set on the wrong edge");
      AST_FLAG_SET: assert property (
         (polarity[k] ? $rose(state[k]) : $fell(state[k])) && enable[k] |-> ##[0:2] flags[k])
         else $error("enabled edge not latched in flags");
   end
   for (genvar j = 0; j < IRQ_N; j++) begin : g_irq
      AST_IRQ_ONE: assert property (irq_pulse[j] |=> !irq_pulse[j])
         else $error("interrupt pulse longer than one cycle");
   end
   AST_IRQ_CAUSE: assert property (|irq_pulse
      |-> $past(flag_any) || $past(flag_any, 2) || $past(flag_any, 3))
      else $error("interrupt pulse without a pending flag");
   AST_RSVD: assert property (!state[EV_RSVD] && !flags[EV_RSVD])
      else $error("reserved event became active");
endmodule : dmaed_link_monitor
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import dmaed_pkg::*;
   typedef struct {logic rd; logic [31:0] d; logic err;} dmaed_apb_type;
   typedef struct {logic [4:0] evt; logic [31:0] ent; logic [3:0][31:0] x;} dmaed_exp_type;
   localparam int PIN_EVT [27] = '{2, 3, 15, 16, 4, 6, 8, 5, 7, 9, 12, 13, 14, 19, 21, 20, 22,
      26, 27, 28, 26, 27, 28, 26, 27, 28, 29};
   logic i_sys_clk, i_rst_n, psel, penable, pwrite, o_pready, o_pslverr, o_irq, clk_en;
   logic [7:0] paddr;
   logic [31:0] pwdata, o_prdata;
   logic [26:0] pins;
   logic [1:0] eng_ack, o_eng_req, seen;
   logic [1:0][4:0] o_eng_evt_num;
   logic [1:0][31:0] o_eng_evt_entry;
   logic [1:0][3:0][31:0] o_eng_xfer;
   logic [31:0] xw [2][4][4];
   int miscompares = 0;
   int num_checks = 0;
   int seed = 84804;
   int dly [2];
   dmaed_apb_type aq [$];
   dmaed_exp_type eq [2][$];
   dmaed_link_if dmaed_link_if_i ();
   dmaed_ctrl dmaed_ctrl_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_clk_en(clk_en),
      .link(dmaed_link_if_i.ctl), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
      .o_pslverr(o_pslverr), .o_irq(o_irq));
   dmaed_device dmaed_device_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_clk_en(clk_en),
      .link(dmaed_link_if_i.dev), .i_counter_request(pins[3:0]), .i_audio_tx_req(pins[6:4]),
      .i_audio_rx_req(pins[9:7]), .i_host_port_interrupt(pins[10]), .i_spi_rx_req(pins[12:11]),
      .i_i2c_tx_req(pins[14:13]), .i_i2c_rx_req(pins[16:15]),
      .i_external_mute_input(pins[19:17]), .i_audio_tx_err(pins[22:20]),
      .i_audio_rx_err(pins[25:23]), .i_counter_overflow_error(pins[26]), .i_eng_ack(eng_ack),
      .o_eng_req(o_eng_req), .o_eng_evt_num(o_eng_evt_num), .o_eng_evt_entry(o_eng_evt_entry),
      .o_eng_xfer(o_eng_xfer));
   dmaed_link_monitor dmaed_link_monitor_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
      .polarity(dmaed_link_if_i.polarity), .enable(dmaed_link_if_i.enable),
      .soft_trig(dmaed_link_if_i.soft_trig), .flags(dmaed_link_if_i.flags),
      .state(dmaed_link_if_i.state), .irq_pulse(dmaed_link_if_i.irq_pulse));
   // 250 mhz system clock
   initial begin
      i_sys_clk = 1'b0;
      forever #2 i_sys_clk = ~i_sys_clk;
   end
   task automatic check(input string nm, input logic [31:0] seen_v, input logic [31:0] exp_v);
      num_checks++;
      if (seen_v !== exp_v) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, exp_v, seen_v);
      end
   endtask : check
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : wrap_up
   task automatic give_up(input string nm);
      miscompares++;
      $display("BAD %s expected done seen timeout", nm);
      wrap_up();
   endtask : give_up
   // one apb transfer; the answer is judged by the watcher below
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         input logic [31:0] ed = 32'h0, input logic ee = 1'b0);
      int n;
      aq.push_back('{!w, ed, ee});
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_sys_clk);
         n++;
      end while (o_pready !== 1'b1 && n < 20);
      if (n >= 20) give_up("pready");
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge i_sys_clk);
   endtask : apb
   task automatic mem_wr(input int g, input int a, input logic [31:0] d);
      apb(1'b1, REG_MEM_ADDR, {25'h0, g == GRP_HI, a[5:0]});
      apb(1'b1, REG_MEM_DATA, d);
   endtask : mem_wr
   task automatic expect_req(input int g, input logic [4:0] ev, input logic [31:0] ent, int p);
      dmaed_exp_type e;
      e.evt = ev;
      e.ent = ent;
      for (int k = 0; k < 4; k++) e.x[k] = xw[g][p][k];
      eq[g].push_back(e);
   endtask : expect_req
   // long settle so a stray dispatch has time to show up as unexpected
   task automatic drain();
      int n = 0;
      while ((eq[0].size() + eq[1].size() > 0 || o_eng_req !== 2'b00 || seen !== 2'b00)
            && n < 300) begin
         @(posedge i_sys_clk);
         n++;
      end
      if (n >= 300) give_up("dispatch");
      repeat (16) @(posedge i_sys_clk);
   endtask : drain
   // apb watcher: oldest note against each completed transfer
   always @(posedge i_sys_clk) begin
      dmaed_apb_type e;
      if (o_pready === 1'b1 && psel && penable) begin
         e = aq.pop_front();
         check("pslverr", o_pslverr, e.err);
         if (e.rd) check("prdata", o_prdata, e.d);
      end
   end
   // engine side: compare each new request, then ack after a random stall
   always @(posedge i_sys_clk) begin
      dmaed_exp_type e;
      logic go;
      for (int g = 0; g < 2; g++) begin
         go = 1'b0;
         if (o_eng_req[g] === 1'b1 && !seen[g] && !eng_ack[g]) begin
            if (eq[g].size() == 0) begin
               check("unexpected request", 32'h1, 32'h0);
            end else begin
               e = eq[g].pop_front();
               check("event number", o_eng_evt_num[g], e.evt);
               check("event entry", o_eng_evt_entry[g], e.ent);
               for (int k = 0; k < 4; k++) begin
                  check("xfer word", o_eng_xfer[g][k], e.x[k]);
               end
            end
            seen[g] <= 1'b1;
            dly[g] = $unsigned($random(seed)) % 4;
         end else if (seen[g] === 1'b1) begin
            go = (dly[g] == 0);
            if (go) seen[g] <= 1'b0;
            dly[g]--;
         end
         eng_ack[g] <= go;
      end
   end
   initial begin
      int n;
      i_rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pins = 27'h0;
      eng_ack = 2'b00;
      clk_en = 1'b1;
      seen = 2'b00;
      repeat (6) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      @(posedge i_sys_clk);
      // reset values, a read-only write and an unmapped offset
      apb(1'b0, REG_POL, 32'h0, RST_ZERO);
      apb(1'b0, REG_ENA, 32'h0, RST_ZERO);
      apb(1'b1, REG_FLAG, 32'hffff_ffff);
      apb(1'b0, REG_FLAG, 32'h0, RST_ZERO);
      apb(1'b0, 8'h40, 32'h0, RST_ZERO, 1'b1);
      // entries before enables; decoys in the wrong memory catch a bad fetch
      for (int g = 0; g < 2; g++) begin
         for (int p = 1; p < 4; p++) begin
            for (int k = 0; k < 4; k++) begin
               xw[g][p][k] = $random(seed);
               mem_wr(g, XFER_BASE + p * 4 + k, xw[g][p][k]);
            end
         end
      end
      mem_wr(GRP_HI, 0, 32'h2);
      mem_wr(GRP_HI, 2, 32'h4);
      mem_wr(GRP_HI, 3, 32'h6);
      mem_wr(GRP_HI, 10, 32'h2);
      mem_wr(GRP_LO, 0, 32'h6);
      mem_wr(GRP_LO, 10, 32'h4);
      mem_wr(GRP_LO, 17, 32'h51);
      apb(1'b1, REG_POL, 32'hffff_ffff);
      apb(1'b1, REG_GRP, 32'h0000_000d);
      apb(1'b0, REG_GRP, 32'h0, 32'h0000_000d);
      apb(1'b1, REG_IRQ_MASK, 32'h20);
      // events 0, 2, 3, 10 and 17 are used below
      apb(1'b1, REG_ENA, 32'h0002_040d);
      // one soft event per group at once
      expect_req(GRP_HI, 5'd0, 32'h2, 1);
      expect_req(GRP_LO, 5'd10, 32'h4, 2);
      apb(1'b1, REG_SOFT, 32'h3);
      drain();
      apb(1'b0, REG_STATE, 32'h0, 32'h0000_0401);
      apb(1'b0, REG_FLAG, 32'h0, RST_ZERO);
      apb(1'b1, REG_SOFT, 32'h0);
      drain();
      // two simultaneous high events, lowest number first
      expect_req(GRP_HI, 5'd2, 32'h4, 2);
      expect_req(GRP_HI, 5'd3, 32'h6, 3);
      pins <= 27'h3;
      drain();
      pins <= 27'h0;
      drain();
      // falling polarity on event 2: the rise must not dispatch
      apb(1'b1, REG_POL, 32'hffff_fffb);
      pins <= 27'h1;
      drain();
      expect_req(GRP_HI, 5'd2, 32'h4, 2);
      pins <= 27'h0;
      drain();
      // interrupt entry, then the same event with the mask cleared
      apb(1'b1, REG_SOFT, 32'h4);
      n = 0;
      while (o_irq !== 1'b1 && n < 30) begin
         @(posedge i_sys_clk);
         n++;
      end
      if (n >= 30) give_up("irq");
      check("irq raised", o_irq, 32'h1);
      apb(1'b0, REG_IRQ_STAT, 32'h0, 32'h20);
      repeat (2) @(posedge i_sys_clk);
      check("irq after clear", o_irq, 32'h0);
      apb(1'b1, REG_IRQ_MASK, 32'h0);
      apb(1'b1, REG_SOFT, 32'h0);
      apb(1'b1, REG_SOFT, 32'h4);
      repeat (16) @(posedge i_sys_clk);
      check("masked irq", o_irq, 32'h0);
      apb(1'b0, REG_IRQ_STAT, 32'h0, 32'h20);
      apb(1'b0, REG_IRQ_STAT, 32'h0, RST_ZERO);
      // each peripheral pin alone, all events disabled
      apb(1'b1, REG_ENA, RST_ZERO);
      apb(1'b1, REG_SOFT, 32'h0);
      for (int i = 0; i < 27; i++) begin
         pins <= 27'h1 << i;
         repeat (5) @(posedge i_sys_clk);
         check("event state", dmaed_link_if_i.state, 32'h1 << PIN_EVT[i]);
         pins <= 27'h0;
         repeat (5) @(posedge i_sys_clk);
      end
      // clock enable low must freeze the pin pipeline, then let it run on
      clk_en <= 1'b0;
      pins <= 27'h1;
      repeat (8) @(posedge i_sys_clk);
      check("frozen state", dmaed_link_if_i.state, RST_ZERO);
      clk_en <= 1'b1;
      repeat (5) @(posedge i_sys_clk);
      check("thawed state", dmaed_link_if_i.state, 32'h4);
      pins <= 27'h0;
      repeat (5) @(posedge i_sys_clk);
      drain();
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
